// ---- core/crr_can_report.sv ----
// CAN register reporting and command handling
`timescale 1ns/1ps
module crr_can_report
  import crr_pkg::*;
#(
  parameter int SLOTS = SLOT_NUM,
  parameter int NALM  = ALARM_NUM
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // Report table load
  input  wire logic                 cfg_we,
  input  wire logic [SLOT_AW-1:0]   cfg_slot,
  input  wire logic                 cfg_en,
  input  wire logic [REG_AW-1:0]    cfg_reg,
  input  wire logic [ID_W-1:0]      cfg_id,
  input  wire crr_vtype_type        cfg_vtype,
  input  wire logic [SLOT_AW-1:0]   cfg_cnt,
  // Command identifiers
  input  wire logic [ID_W-1:0]      cmd_conn_id,
  input  wire logic [ID_W-1:0]      cmd_clr_id,
  input  wire logic [ID_W-1:0]      cmd_hb_id,
  input  wire logic [2:0]           cmd_en,
  // Heartbeat watchdog
  input  wire logic                 wd_en,
  input  wire logic [31:0]          wd_cycles,
  // Register source
  input  wire logic                 report_tick,
  output logic [REG_AW-1:0]         reg_addr_q,
  input  wire logic [DATA_W-1:0]    reg_data,
  // Transmit frame
  output logic                      tx_valid_q,
  output logic [ID_W-1:0]           tx_id_q,
  output logic                      tx_ide_q,
  output logic                      tx_rtr_q,
  output logic [3:0]                tx_dlc_q,
  output logic [DATA_W-1:0]         tx_data_q,
  input  wire logic                 tx_ready,
  // Receive frame
  input  wire logic                 rx_valid,
  input  wire logic [ID_W-1:0]      rx_id,
  input  wire logic                 rx_ide,
  input  wire logic                 rx_rtr,
  input  wire logic [3:0]           rx_dlc,
  input  wire logic [DATA_W-1:0]    rx_data,
  // Alarms and contactors
  input  wire logic [NALM-1:0]      fault_cond,
  input  wire logic [NALM-1:0]      warn_cond,
  output logic [NALM-1:0]           fault_latch_q,
  output logic [NALM-1:0]           warn_latch_q,
  output logic                      stack_fault_q,
  output logic                      contactor_close_q,
  output logic [15:0]               hb_last_q,
  output logic [7:0]                bit_div_q,
  output logic                      busy_q
);

  if (SLOTS < 1 || SLOTS > SLOT_NUM) begin : g_bad_slots
    $error("SLOTS must lie between 1 and 64");
  end
  if (NALM < 1) begin : g_bad_nalm
    $error("NALM must be at least 1");
  end

  logic                slot_en_q   [SLOTS];
  logic [REG_AW-1:0]   slot_reg_q  [SLOTS];
  logic [ID_W-1:0]     slot_id_q   [SLOTS];
  crr_vtype_type       slot_vt_q   [SLOTS];
  logic [SLOT_AW-1:0]  slot_cnt_q  [SLOTS];

  crr_state_type       state_q;
  logic [SLOT_AW-1:0]  slot_q;
  logic [SLOT_AW-1:0]  sub_q;
  logic                last_slot;
  logic                conn_stb;
  logic                conn_close;
  logic                clr_fault;
  logic                clr_warn;
  logic                hb_stb;
  logic [15:0]         hb_val;
  logic                conn_q;
  logic [31:0]         wd_cnt_q;
  logic                wd_expired;

  assign last_slot  = slot_q == SLOT_AW'(SLOTS - 1);
  assign wd_expired = wd_en && wd_cnt_q >= wd_cycles;

  crr_cmd_decode u_cmd (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .rx_valid     (rx_valid),
    .rx_id        (rx_id),
    .rx_ide       (rx_ide),
    .rx_rtr       (rx_rtr),
    .rx_dlc       (rx_dlc),
    .rx_data      (rx_data),
    .cmd_conn_id  (cmd_conn_id),
    .cmd_clr_id   (cmd_clr_id),
    .cmd_hb_id    (cmd_hb_id),
    .cmd_en       (cmd_en),
    .conn_stb_q   (conn_stb),
    .conn_close_q (conn_close),
    .clr_fault_q  (clr_fault),
    .clr_warn_q   (clr_warn),
    .hb_stb_q     (hb_stb),
    .hb_val_q     (hb_val)
  );

  // Report table enables
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_en_q[i] <= 1'b0;
      end
    end else if (cfg_we && int'(cfg_slot) < SLOTS) begin
      slot_en_q[cfg_slot] <= cfg_en;
    end
  end

  // Report table contents
  always_ff @(posedge ref_clk) begin
    if (cfg_we && int'(cfg_slot) < SLOTS) begin
      slot_reg_q[cfg_slot] <= cfg_reg;
      slot_id_q[cfg_slot]  <= cfg_id;
      slot_vt_q[cfg_slot]  <= cfg_vtype;
      slot_cnt_q[cfg_slot] <= cfg_cnt;
    end
  end

  // Report sequencer and transmit frame
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      slot_q     <= '0;
      sub_q      <= '0;
      reg_addr_q <= '0;
      tx_valid_q <= 1'b0;
      tx_id_q    <= '0;
      tx_ide_q   <= 1'b0;
      tx_rtr_q   <= 1'b0;
      tx_dlc_q   <= DLC_MIN;
      tx_data_q  <= '0;
      busy_q     <= 1'b0;
    end else begin
      tx_ide_q <= 1'b0;
      tx_rtr_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (report_tick) begin
            slot_q  <= '0;
            sub_q   <= '0;
            busy_q  <= 1'b1;
            state_q <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (slot_en_q[slot_q]) begin
            reg_addr_q <= slot_reg_q[slot_q] + REG_AW'(sub_q);
            state_q    <= ST_FETCH;
          end else if (last_slot) begin
            busy_q  <= 1'b0;
            state_q <= ST_IDLE;
          end else begin
            slot_q <= slot_q + 1'b1;
          end
        end
        ST_FETCH: begin
          tx_valid_q <= 1'b1;
          tx_id_q    <= slot_id_q[slot_q] + ID_W'(sub_q);
          tx_dlc_q   <= crr_size(slot_vt_q[slot_q]);
          tx_data_q  <= crr_mask(reg_data, slot_vt_q[slot_q]);
          state_q    <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_ready) begin
            tx_valid_q <= 1'b0;
            if (sub_q != slot_cnt_q[slot_q]) begin
              sub_q   <= sub_q + 1'b1;
              state_q <= ST_SCAN;
            end else if (last_slot) begin
              sub_q   <= '0;
              busy_q  <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              sub_q   <= '0;
              slot_q  <= slot_q + 1'b1;
              state_q <= ST_SCAN;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Bit-time divider for the link
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bit_div_q <= BIT_DIV_RST;
    end else begin
      bit_div_q <= BIT_DIV_RST;
    end
  end

  // Heartbeat watchdog
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wd_cnt_q  <= WD_CNT_RST;
      hb_last_q <= 16'h0000;
    end else begin
      if (hb_stb) begin
        hb_last_q <= hb_val;
      end
      if (!wd_en || hb_stb) begin
        wd_cnt_q <= WD_CNT_RST;
      end else if (!wd_expired) begin
        wd_cnt_q <= wd_cnt_q + 32'h1;
      end
    end
  end

  // Stack fault and contactor command
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stack_fault_q     <= 1'b0;
      conn_q            <= 1'b0;
      contactor_close_q <= 1'b0;
    end else begin
      if (wd_expired) begin
        stack_fault_q <= 1'b1;
      end else if (clr_fault) begin
        stack_fault_q <= 1'b0;
      end
      if (wd_expired) begin
        conn_q <= 1'b0;
      end else if (conn_stb) begin
        conn_q <= conn_close;
      end
      contactor_close_q <= conn_q && !stack_fault_q && !wd_expired;
    end
  end

  // Latched alarms
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fault_latch_q <= '0;
      warn_latch_q  <= '0;
    end else begin
      fault_latch_q <= clr_fault ? fault_cond : (fault_latch_q | fault_cond);
      warn_latch_q  <= clr_warn ? warn_cond : (warn_latch_q | warn_cond);
    end
  end

  frame_form_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_valid_q |-> !tx_rtr_q && !tx_ide_q && tx_dlc_q >= DLC_MIN && tx_dlc_q <= DLC_MAX)
    else $error("transmitted frame has an illegal format");

  tx_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_id_q) && $stable(tx_data_q))
    else $error("frame changed before it was taken");

  tx_id_map_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_valid_q |-> tx_id_q == slot_id_q[slot_q] + ID_W'(sub_q))
    else $error("frame identifier differs from the configured one");

  dlc_type_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_valid_q |-> tx_dlc_q == crr_size(slot_vt_q[slot_q]))
    else $error("payload length does not follow the register type");

  int32_len_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_valid_q && slot_vt_q[slot_q] == VT_I32 |-> tx_dlc_q == 4'h4)
    else $error("signed 32-bit register not sent as four bytes");

  bulk_next_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_valid_q && tx_ready && sub_q != slot_cnt_q[slot_q]
    |=> state_q == ST_SCAN ##1 state_q == ST_FETCH ##1 tx_valid_q)
    else $error("bulk set did not continue with its next frame");

  wd_fault_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wd_expired |=> stack_fault_q ##1 !contactor_close_q)
    else $error("watchdog expiry did not fault and open contactors");

  alarm_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clr_fault |=> (fault_latch_q & $past(fault_cond)) == $past(fault_cond))
    else $error("fault cleared while its condition was present");

  warn_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clr_fault && !clr_warn |=> (warn_latch_q & $past(warn_latch_q)) == $past(warn_latch_q))
    else $error("fault clear dropped a latched warning");

  warn_reload_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    clr_warn |=> (warn_latch_q & $past(warn_cond)) == $past(warn_cond))
    else $error("warning cleared while its condition was present");

  stack_open_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    stack_fault_q |=> !contactor_close_q)
    else $error("contactors closed during a stack fault");

  wd_refresh_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    hb_stb |=> wd_cnt_q == WD_CNT_RST)
    else $error("heartbeat did not restart the watchdog");

  round_end_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_q == ST_IDLE |-> !busy_q && !tx_valid_q)
    else $error("idle sequencer still busy or sending");

endmodule

// ---- core/crr_pkg.sv ----
// Constants, types and helpers for the CAN register reporting block
// Operation
// - Frames follow CAN 2.0 framing but remote frames are never sent and received ones are ignored.
// - The link runs at a fixed 500 kbit/s on both ends.
// - Every frame uses the base format with an 11-bit identifier, never an extended one.
// - Each sent frame carries 1 to 8 data bytes, chosen from the size of its register.
// - Each reported register is sent under the CAN identifier configured for it.
// - A configuration table selects up to 64 registers for reporting.
// - A bulk entry sends a whole set of related measurements as a series of frames.
// - Configured command frames request connect or disconnect, alarm clearing, or heartbeat update.
// - The payload length of a register follows its variable type both ways.
// - A signed 32-bit register takes exactly four payload bytes.
// - A heartbeat not refreshed within the watchdog period raises a stack fault and opens contactors.
// - An alarm clear leaves set any latched alarm whose condition is still present.
// - The generic alarm clear clears faults only and leaves warnings latched; the clear command also clears warnings when bit 1 of its value is set.
package crr_pkg;

  localparam int ID_W         = 11;
  localparam int REG_AW       = 8;
  localparam int SLOT_AW      = 6;
  localparam int SLOT_NUM     = 64;
  localparam int ALARM_NUM    = 8;
  localparam int DATA_W       = 64;
  localparam int CAN_KBPS     = 500;
  localparam int REF_CLK_KHZ  = 25000;
  localparam int BIT_CYCLES   = REF_CLK_KHZ / CAN_KBPS;
  localparam int CMD_EN_CONN  = 0;
  localparam int CMD_EN_CLR   = 1;
  localparam int CMD_EN_HB    = 2;
  localparam int CLR_FAULT_B  = 0;
  localparam int CLR_WARN_B   = 1;
  localparam logic [15:0] CONN_CLOSE_VAL = 16'h0001;
  localparam logic [3:0]  CMD_DLC        = 4'h2;
  localparam logic [3:0]  DLC_MIN        = 4'h1;
  localparam logic [3:0]  DLC_MAX        = 4'h8;
  localparam logic [7:0]  BIT_DIV_RST    = 8'(BIT_CYCLES);
  localparam logic [31:0] WD_CNT_RST     = 32'h0;

  typedef enum logic [2:0] {
    VT_U8, VT_I8, VT_U16, VT_I16, VT_U32, VT_I32, VT_F32, VT_U64
  } crr_vtype_type;

  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_FETCH, ST_SEND} crr_state_type;

  // Payload bytes of a variable type
  function automatic logic [3:0] crr_size(input crr_vtype_type vt);
    case (vt)
      VT_U8, VT_I8:          crr_size = 4'h1;
      VT_U16, VT_I16:        crr_size = 4'h2;
      VT_U32, VT_I32, VT_F32: crr_size = 4'h4;
      default:               crr_size = 4'h8;
    endcase
  endfunction

  // Keep only the payload bytes of a value
  function automatic logic [DATA_W-1:0] crr_mask(input logic [DATA_W-1:0] v,
                                                 input crr_vtype_type     vt);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(crr_size(vt))) begin
        m[i*8 +: 8] = 8'hFF;
      end
    end
    crr_mask = v & m;
  endfunction

endpackage

// ---- core/crr_cmd_decode.sv ----
// Decoder of incoming command frames
`timescale 1ns/1ps
module crr_cmd_decode
  import crr_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Received frame
  input  wire logic              rx_valid,
  input  wire logic [ID_W-1:0]   rx_id,
  input  wire logic              rx_ide,
  input  wire logic              rx_rtr,
  input  wire logic [3:0]        rx_dlc,
  input  wire logic [DATA_W-1:0] rx_data,
  // Command identifiers
  input  wire logic [ID_W-1:0]   cmd_conn_id,
  input  wire logic [ID_W-1:0]   cmd_clr_id,
  input  wire logic [ID_W-1:0]   cmd_hb_id,
  input  wire logic [2:0]        cmd_en,
  // Decoded commands
  output logic                   conn_stb_q,
  output logic                   conn_close_q,
  output logic                   clr_fault_q,
  output logic                   clr_warn_q,
  output logic                   hb_stb_q,
  output logic [15:0]            hb_val_q
);

  logic        frame_ok;
  logic [15:0] val;

  assign frame_ok = rx_valid && !rx_ide && !rx_rtr && rx_dlc == CMD_DLC;
  assign val      = rx_data[15:0];

  // One-cycle command strobes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conn_stb_q   <= 1'b0;
      conn_close_q <= 1'b0;
      clr_fault_q  <= 1'b0;
      clr_warn_q   <= 1'b0;
      hb_stb_q     <= 1'b0;
      hb_val_q     <= 16'h0000;
    end else begin
      conn_stb_q  <= frame_ok && cmd_en[CMD_EN_CONN] && rx_id == cmd_conn_id;
      clr_fault_q <= frame_ok && cmd_en[CMD_EN_CLR] && rx_id == cmd_clr_id && val[CLR_FAULT_B];
      clr_warn_q  <= frame_ok && cmd_en[CMD_EN_CLR] && rx_id == cmd_clr_id && val[CLR_WARN_B];
      hb_stb_q    <= frame_ok && cmd_en[CMD_EN_HB] && rx_id == cmd_hb_id;
      if (frame_ok && rx_id == cmd_conn_id) begin
        conn_close_q <= val == CONN_CLOSE_VAL;
      end
      if (frame_ok && rx_id == cmd_hb_id) begin
        hb_val_q <= val;
      end
    end
  end

  bad_frame_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    rx_valid && (rx_rtr || rx_ide || rx_dlc != CMD_DLC)
    |=> !(conn_stb_q || clr_fault_q || clr_warn_q || hb_stb_q))
    else $error("malformed frame produced a command");

  unknown_id_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    rx_valid && rx_id != cmd_conn_id && rx_id != cmd_clr_id && rx_id != cmd_hb_id
    |=> !(conn_stb_q || clr_fault_q || clr_warn_q || hb_stb_q))
    else $error("unconfigured identifier produced a command");

endmodule

// ---- test/crr_ctrl_model.sv ----
// Model of the external system controller on the CAN side
`timescale 1ns/1ps
module crr_ctrl_model
  import crr_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Frames from the device
  input  wire logic              tx_valid_q,
  input  wire logic [ID_W-1:0]   tx_id_q,
  input  wire logic              tx_ide_q,
  input  wire logic              tx_rtr_q,
  input  wire logic [3:0]        tx_dlc_q,
  input  wire logic [DATA_W-1:0] tx_data_q,
  output logic                   tx_ready,
  // Frames to the device
  output logic                   rx_valid,
  output logic [ID_W-1:0]        rx_id,
  output logic                   rx_ide,
  output logic                   rx_rtr,
  output logic [3:0]             rx_dlc,
  output logic [DATA_W-1:0]      rx_data
);
  int                stall  = 0;
  int                wcnt   = 0;
  int                n_bad  = 0;
  logic [15:0]       hb_cnt = 16'h0000;
  logic [ID_W-1:0]   q_id[$];
  logic [3:0]        q_dlc[$];
  logic [DATA_W-1:0] q_data[$];

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_id = '0;
    rx_ide = 1'b0;
    rx_rtr = 1'b0;
    rx_dlc = 4'h0;
    rx_data = '0;
  end

  // Take frames, promptly or after stall cycles
  always @(posedge ref_clk) begin
    if (tx_valid_q === 1'b1 && tx_ready === 1'b1) begin
      if (tx_ide_q !== 1'b0 || tx_rtr_q !== 1'b0) n_bad++;
      q_id.push_back(tx_id_q);
      q_dlc.push_back(tx_dlc_q);
      q_data.push_back(tx_data_q);
    end
    #1;
    if (tx_valid_q === 1'b1) begin
      wcnt++;
      tx_ready = (wcnt > stall);
    end else begin
      wcnt = 0;
      tx_ready = 1'b0;
    end
  end

  // One received frame, two payload bytes little-endian
  task automatic send(input logic [ID_W-1:0] id, input logic ide, input logic rtr,
                      input logic [3:0] dlc, input logic [15:0] v);
    @(posedge ref_clk);
    #1;
    rx_id = id;
    rx_ide = ide;
    rx_rtr = rtr;
    rx_dlc = dlc;
    rx_data = {48'h0, v};
    rx_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_id = ~rx_id;
  endtask

  // Heartbeat that rises and wraps past 16 bits
  task automatic send_hb(input logic [ID_W-1:0] id);
    send(id, 1'b0, 1'b0, CMD_DLC, hb_cnt);
    hb_cnt = hb_cnt + 16'h0001;
  endtask
endmodule

// ---- test/crr_can_report_test.sv ----
// Self-checking bench for CAN register reporting
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module crr_can_report_test
  import crr_pkg::*;
;
  logic              ref_clk = 1'b0, resetn = 1'b0, cfg_we = 1'b0, cfg_en = 1'b0;
  logic              wd_en = 1'b0, report_tick = 1'b0;
  logic [SLOT_AW-1:0] cfg_slot = '0, cfg_cnt = '0;
  logic [REG_AW-1:0] cfg_reg = '0, reg_addr_q;
  logic [ID_W-1:0]   cfg_id = '0, cmd_conn_id = 11'h010, cmd_clr_id = 11'h011;
  logic [ID_W-1:0]   cmd_hb_id = 11'h012, tx_id_q, rx_id;
  crr_vtype_type     cfg_vtype = VT_U8;
  logic [2:0]        cmd_en = 3'h7;
  logic [31:0]       wd_cycles = 32'h14;
  logic [DATA_W-1:0] reg_data, tx_data_q, rx_data;
  logic              tx_valid_q, tx_ide_q, tx_rtr_q, tx_ready, rx_valid, rx_ide, rx_rtr;
  logic              stack_fault_q, contactor_close_q, busy_q;
  logic [3:0]        tx_dlc_q, rx_dlc;
  logic [7:0]        fault_cond = '0, warn_cond = '0, fault_latch_q, warn_latch_q, bit_div_q;
  logic [15:0]       hb_last_q;
  int                err_total = 0, n_compared = 0, cyc = 0;

  always #20 ref_clk = ~ref_clk;
  assign reg_data = {8{reg_addr_q}} ^ 64'h0123456789ABCDEF;

  crr_can_report uut (.ref_clk, .resetn, .cfg_we, .cfg_slot, .cfg_en, .cfg_reg, .cfg_id,
    .cfg_vtype, .cfg_cnt, .cmd_conn_id, .cmd_clr_id, .cmd_hb_id, .cmd_en, .wd_en, .wd_cycles,
    .report_tick, .reg_addr_q, .reg_data, .tx_valid_q, .tx_id_q, .tx_ide_q, .tx_rtr_q,
    .tx_dlc_q, .tx_data_q, .tx_ready, .rx_valid, .rx_id, .rx_ide, .rx_rtr, .rx_dlc, .rx_data,
    .fault_cond, .warn_cond, .fault_latch_q, .warn_latch_q, .stack_fault_q,
    .contactor_close_q, .hb_last_q, .bit_div_q, .busy_q);
  crr_ctrl_model ctrl (.ref_clk, .tx_valid_q, .tx_id_q, .tx_ide_q, .tx_rtr_q, .tx_dlc_q,
    .tx_data_q, .tx_ready, .rx_valid, .rx_id, .rx_ide, .rx_rtr, .rx_dlc, .rx_data);

  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic cfg(int s, logic en, int r, int id, int vt, int cnt);
    step();
    cfg_we = 1'b1;
    cfg_slot = SLOT_AW'(s);
    cfg_en = en;
    cfg_reg = REG_AW'(r);
    cfg_id = ID_W'(id);
    cfg_vtype = crr_vtype_type'(vt);
    cfg_cnt = SLOT_AW'(cnt);
    step();
    cfg_we = 1'b0;
  endtask

  // Start a round, optionally tick again while busy, wait for its end
  task automatic round(bit twice);
    step();
    report_tick = 1'b1;
    step();
    report_tick = 1'b0;
    step(2);
    if (twice) begin
      report_tick = 1'b1;
      step();
      report_tick = 1'b0;
    end
    for (int i = 0; i < 3000 && busy_q !== 1'b0; i++) step();
    step(4);
    `CHK("busy after round", 1'b0, busy_q)
  endtask

  task automatic expect_frame(int id, int vt, int a);
    logic [DATA_W-1:0] d, gd;
    logic [ID_W-1:0]   gi;
    logic [3:0]        gl;
    int                n;
    n = (vt < 2) ? 1 : (vt < 4) ? 2 : (vt < 7) ? 4 : 8;
    d = {8{8'(a)}} ^ 64'h0123456789ABCDEF;
    for (int b = n; b < 8; b++) d[b*8 +: 8] = 8'h00;
    if (ctrl.q_id.size() == 0) begin
      `CHK("frame present", 1, 0)
      return;
    end
    gi = ctrl.q_id.pop_front();
    gl = ctrl.q_dlc.pop_front();
    gd = ctrl.q_data.pop_front();
    `CHK("tx id", ID_W'(id), gi)
    `CHK("tx dlc", 4'(n), gl)
    `CHK("tx data", d, gd)
  endtask

  task automatic t_types;
    for (int t = 0; t < 8; t++) cfg(t, 1'b1, 8'h40 + t, 11'h100 + t, t, 0);
    cfg(63, 1'b1, 8'h7F, 11'h7FF, 2, 0);
    cfg(8, 1'b0, 8'h50, 11'h300, 0, 0);
    ctrl.stall = 2;
    round(1'b0);
    for (int t = 0; t < 8; t++) expect_frame(11'h100 + t, t, 8'h40 + t);
    expect_frame(11'h7FF, 2, 8'h7F);
    `CHK("extra frames", 0, ctrl.q_id.size())
    for (int t = 0; t < 8; t++) cfg(t, 1'b0, 0, 0, 0, 0);
    cfg(63, 1'b0, 0, 0, 0, 0);
  endtask

  task automatic t_bulk;
    cfg(5, 1'b1, 8'h20, 11'h200, 5, 3);
    ctrl.stall = 0;
    round(1'b1);
    for (int k = 0; k < 4; k++) expect_frame(11'h200 + k, 5, 8'h20 + k);
    `CHK("bulk frame total", 0, ctrl.q_id.size())
    cfg(5, 1'b0, 0, 0, 0, 0);
  endtask

  task automatic cmd(int id, int dlc, int v, bit ide = 0, bit rtr = 0);
    ctrl.send(ID_W'(id), ide, rtr, 4'(dlc), 16'(v));
    step(4);
  endtask

  task automatic t_conn;
    cmd(11'h010, 2, 1);
    `CHK("close", 1'b1, contactor_close_q)
    cmd(11'h010, 3, 0);
    `CHK("bad length", 1'b1, contactor_close_q)
    cmd(11'h013, 2, 0);
    `CHK("unknown id", 1'b1, contactor_close_q)
    cmd(11'h010, 2, 0, 0, 1);
    `CHK("remote frame", 1'b1, contactor_close_q)
    cmd(11'h010, 2, 0, 1, 0);
    `CHK("extended frame", 1'b1, contactor_close_q)
    cmd_en = 3'h6;
    cmd(11'h010, 2, 0);
    `CHK("disabled command", 1'b1, contactor_close_q)
    cmd_en = 3'h7;
    cmd(11'h010, 2, 0);
    `CHK("open", 1'b0, contactor_close_q)
  endtask

  task automatic t_alarm;
    fault_cond = 8'h03;
    warn_cond = 8'h10;
    step(4);
    `CHK("fault latch", 8'h03, fault_latch_q)
    `CHK("warn latch", 8'h10, warn_latch_q)
    fault_cond = 8'h01;
    warn_cond = 8'h00;
    cmd(11'h011, 2, 1);
    `CHK("fault kept", 8'h01, fault_latch_q)
    `CHK("warn kept", 8'h10, warn_latch_q)
    cmd(11'h011, 2, 2);
    `CHK("warn cleared", 8'h00, warn_latch_q)
    fault_cond = 8'h00;
    cmd(11'h011, 2, 1);
    `CHK("fault cleared", 8'h00, fault_latch_q)
  endtask

  task automatic t_wd;
    cmd(11'h010, 2, 1);
    ctrl.hb_cnt = 16'hFFFE;
    ctrl.send_hb(11'h012);
    wd_en = 1'b1;
    for (int k = 0; k < 3; k++) begin
      step(8);
      ctrl.send_hb(11'h012);
    end
    step(4);
    `CHK("heartbeat wrap", 16'h0001, hb_last_q)
    `CHK("fed watchdog", 1'b0, stack_fault_q)
    `CHK("fed contactor", 1'b1, contactor_close_q)
    step(30);
    `CHK("expired fault", 1'b1, stack_fault_q)
    `CHK("expired contactor", 1'b0, contactor_close_q)
    wd_en = 1'b0;
    cmd(11'h011, 2, 1);
    `CHK("fault cleared", 1'b0, stack_fault_q)
    cmd_en = 3'h3;
    ctrl.send_hb(11'h012);
    step(4);
    `CHK("disabled heartbeat", 16'h0001, hb_last_q)
    cmd_en = 3'h7;
  endtask

  initial begin
    step(12);
    resetn = 1'b1;
    step();
    `CHK("dlc at reset", 4'h1, tx_dlc_q)
    `CHK("bit divider", 8'h32, bit_div_q)
    `CHK("contactor at reset", 1'b0, contactor_close_q)
    t_types();
    t_bulk();
    t_conn();
    t_alarm();
    t_wd();
    `CHK("frame format", 0, ctrl.n_bad)
    end_sim();
  end
endmodule
